/* File: src/lbim_pkg.sv */
`default_nettype none

package lbim_pkg;

   // Width of the register port address, covering the direct access range.
   localparam int ADDR_W = 18;

   // Byte offsets of the registers on the register port.
   localparam logic [17:0] OFS_MISC_CFG = 18'h0000C;
   localparam logic [17:0] OFS_STATUS = 18'h00500;
   localparam logic [17:0] OFS_MASK = 18'h00504;
   localparam logic [17:0] OFS_ENABLE = 18'h00508;
   localparam logic [17:0] OFS_D2H_MBOX = 18'h00600;
   localparam logic [17:0] OFS_H2D_MBOX = 18'h00604;
   localparam logic [17:0] OFS_WINDOW = 18'h20000;

   // Address bit that selects the direct access range.
   localparam int WINDOW_SEL_BIT = 17;

   // Number of implemented status, mask and mailbox bits.
   localparam int STATUS_W = 19;
   localparam int MBOX_W = 16;
   localparam int LB_ADDR_W = 15;

   // Status bit positions.
   localparam int BIT_TX_DESC = 0;
   localparam int BIT_TX_OK = 1;
   localparam int BIT_TX_ERR = 2;
   localparam int BIT_TX_EOL = 3;
   localparam int BIT_RX_DESC = 4;
   localparam int BIT_RX_OK = 5;
   localparam int BIT_RX_ERR = 6;
   localparam int BIT_RX_EOL = 7;
   localparam int BIT_TRUNC = 8;
   localparam int BIT_STARVE = 9;
   localparam int BIT_TIMEOUT = 10;
   localparam int BIT_PROTO = 11;
   localparam int BIT_MBOX_WR = 12;
   localparam int BIT_MBOX_RD = 13;
   localparam int BIT_HM_TMO_LSB = 14;
   localparam int BIT_HM_IRQ = 18;

   // Miscellaneous configuration fields.
   localparam int MCFG_MBOX_WR_IE = 2;
   localparam int MCFG_MBOX_RD_IE = 3;
   localparam int MCFG_TMO_LSB = 7;
   localparam int MCFG_TMO_MSB = 23;
   localparam int TMO_W = 17;
   localparam logic [31:0] MCFG_WMASK = 32'h07FFFF9F;

   // Timeout counting unit in clock cycles, and its prescaler width.
   localparam int TMO_UNIT_CYC = 128;
   localparam int TMO_PRE_W = 7;
   localparam logic [6:0] TMO_PRE_LAST = 7'(TMO_UNIT_CYC - 1);

   // Values after reset.
   localparam logic [31:0] MCFG_RST = 32'h00000000;
   localparam logic [18:0] STATUS_RST = 19'h00000;
   localparam logic [18:0] MASK_RST = 19'h00000;
   localparam logic ENABLE_RST = 1'b0;
   localparam logic [15:0] MBOX_RST = 16'h0000;

   // One-hot states of the direct access sequencer.
   typedef enum logic [1:0] {
      LBIM_IDLE = 2'b01,
      LBIM_BUSY = 2'b10
   } lbim_dca_state_t;

endpackage : lbim_pkg

`default_nettype wire

/* File: src/lbim_tmo_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Carries a pending indication and its limit to the timeout counter.
interface lbim_tmo_if;
   import lbim_pkg::*;
   logic pending;             // A local bus transaction is outstanding.
   logic [TMO_W-1:0] limit;   // Limit in units; zero disables.
   logic expired;             // One-cycle pulse on expiry.
   modport ctl (output pending, output limit, input expired);
   modport tmr (input pending, input limit, output expired);
endinterface : lbim_tmo_if

`default_nettype wire

/* File: src/lbim_timeout.sv */
`timescale 1ns/1ps
`default_nettype none

module lbim_timeout
   import lbim_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   lbim_tmo_if.tmr tmo
);

   logic [TMO_PRE_W-1:0] pre;  // Cycles within the current unit.
   logic [TMO_W-1:0] units;    // Whole units spent pending.
   logic fired;                // Expiry already reported for this wait.
   wire unit_end = (pre == TMO_PRE_LAST);
   // Expiry once pending has lasted the programmed number of units.
   wire hit = (tmo.limit != '0) && (units == tmo.limit) && !fired;

   // Counting restarts whenever nothing is pending, so each transaction
   // gets a full allowance; the units stop once expiry has fired.
   always_ff @(posedge clk_sys) begin
      if (rst || !tmo.pending) begin
         pre <= '0;
         units <= '0;
         fired <= 1'b0;
         tmo.expired <= 1'b0;
      end else begin
         pre <= TMO_PRE_W'(pre + 1'b1);
         if (unit_end && !fired) begin
            units <= TMO_W'(units + 1'b1);
         end
         fired <= fired | hit;
         tmo.expired <= hit;
      end
   end

endmodule : lbim_timeout

`default_nettype wire

/* File: src/lbim_top.sv */
`timescale 1ns/1ps
`default_nettype none

module lbim_top
   import lbim_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_req,
   input wire logic reg_write,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_ack,
   input wire logic tx_done,
   input wire logic tx_desc_irq_request,
   input wire logic tx_had_error,
   input wire logic tx_next_desc_link_null,
   input wire logic rx_done,
   input wire logic rx_desc_irq_request,
   input wire logic rx_had_error,
   input wire logic rx_next_desc_link_null,
   input wire logic tx_truncated,
   input wire logic tx_starved,
   input wire logic lb_protocol_err,
   input wire logic [2:0] lb_protocol_kind,
   input wire logic lb_txn_pending,
   input wire logic host_mode,
   input wire logic [3:0] slave_timeout,
   input wire logic slave_irq,
   input wire logic lb_mbox_rd,
   input wire logic lb_mbox_wr,
   input wire logic [MBOX_W-1:0] lb_mbox_wdata,
   output logic [MBOX_W-1:0] lb_mbox_rdata,
   output logic host_irq_line,
   output logic irq,
   output logic direct_cpu_access_req,
   output logic direct_cpu_access_write,
   output logic [LB_ADDR_W-1:0] direct_cpu_access_addr,
   output logic [MBOX_W-1:0] direct_cpu_access_wdata,
   input wire logic direct_cpu_access_done,
   input wire logic [MBOX_W-1:0] direct_cpu_access_rdata
);

   // Word compare of a port address against a register offset.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
      reg_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction : reg_hit

   // Register state.
   logic [STATUS_W-1:0] status;        // Sticky event flags.
   logic [STATUS_W-1:0] mask;          // Interrupt selection.
   logic global_enable;                // Master interrupt enable.
   logic [31:0] misc_cfg;              // Miscellaneous configuration.
   logic [MBOX_W-1:0] d2h_mbox;        // Device-to-host mailbox.
   logic [MBOX_W-1:0] h2d_mbox;        // Host-to-device mailbox.
   lbim_dca_state_t dca_state;         // Direct access sequencer.

   // Timeout counter link.
   lbim_tmo_if tmo_if ();

   // Request qualification; a request during a window access is ignored.
   wire idle = (dca_state == LBIM_IDLE);
   wire take = reg_req && idle;
   wire in_window = reg_addr[WINDOW_SEL_BIT];
   wire reg_wr = take && reg_write && !in_window;
   wire reg_rd = take && !reg_write && !in_window;
   wire dca_start = take && in_window;

   // Per-register write and read strobes.
   wire wr_status = reg_wr && reg_hit(reg_addr, OFS_STATUS);
   wire wr_mask = reg_wr && reg_hit(reg_addr, OFS_MASK);
   wire wr_enable = reg_wr && reg_hit(reg_addr, OFS_ENABLE);
   wire wr_misc = reg_wr && reg_hit(reg_addr, OFS_MISC_CFG);
   wire wr_d2h = reg_wr && reg_hit(reg_addr, OFS_D2H_MBOX);
   wire wr_h2d = reg_wr && reg_hit(reg_addr, OFS_H2D_MBOX);
   wire rd_h2d = reg_rd && reg_hit(reg_addr, OFS_H2D_MBOX);

   // Hardware events gathered into one set vector.
   logic [STATUS_W-1:0] status_set;
   always_comb begin
      status_set = '0;
      status_set[BIT_TX_DESC] = tx_done && tx_desc_irq_request;
      status_set[BIT_TX_OK] = tx_done && !tx_had_error;
      status_set[BIT_TX_ERR] = tx_done && tx_had_error;
      status_set[BIT_TX_EOL] = tx_done && tx_next_desc_link_null;
      status_set[BIT_RX_DESC] = rx_done && rx_desc_irq_request;
      status_set[BIT_RX_OK] = rx_done && !rx_had_error;
      status_set[BIT_RX_ERR] = rx_done && rx_had_error;
      status_set[BIT_RX_EOL] = rx_done && rx_next_desc_link_null;
      status_set[BIT_TRUNC] = tx_truncated;
      status_set[BIT_STARVE] = tx_starved;
      status_set[BIT_TIMEOUT] = tmo_if.expired;
      // A protocol violation may also flag the matching cause bits.
      status_set[BIT_PROTO] = lb_protocol_err;
      if (lb_protocol_err) begin
         status_set[BIT_TIMEOUT:BIT_TRUNC] =
            status_set[BIT_TIMEOUT:BIT_TRUNC] | lb_protocol_kind;
      end
      status_set[BIT_MBOX_WR] = lb_mbox_wr;
      status_set[BIT_MBOX_RD] = lb_mbox_rd;
      status_set[BIT_HM_TMO_LSB +: 4] =
         host_mode ? slave_timeout : 4'h0;
      // The level keeps re-setting the bit for as long as it is held.
      status_set[BIT_HM_IRQ] = host_mode && slave_irq;
   end

   // Write-one-to-clear; a set in the same cycle wins over the clear.
   wire [STATUS_W-1:0] status_clr =
      wr_status ? reg_wdata[STATUS_W-1:0] : '0;
   wire [STATUS_W-1:0] next_status =
      (status & ~status_clr) | status_set;

   // One flip-flop per status flag.
   genvar g;
   generate
      for (g = 0; g < STATUS_W; g++) begin : g_status
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               status[g] <= STATUS_RST[g];
            end else begin
               status[g] <= next_status[g];
            end
         end
      end
   endgenerate

   // Next values of the software-owned registers.
   wire [STATUS_W-1:0] next_mask =
      wr_mask ? reg_wdata[STATUS_W-1:0] : mask;
   wire next_enable = wr_enable ? reg_wdata[0] : global_enable;
   wire [31:0] next_misc =
      wr_misc ? (reg_wdata & MCFG_WMASK) : misc_cfg;

   // Interrupt from the next state so it tracks status without lag.
   // The mask never touches the flags themselves.
   wire next_irq = next_enable && |(next_status & next_mask);

   // Host line: enabled CPU writes of d2h_mbox and reads of h2d_mbox raise it, master accesses drop it.
   // A raise in the same cycle as a master access still raises.
   wire host_set =
      (wr_d2h && misc_cfg[MCFG_MBOX_WR_IE]) ||
      (rd_h2d && misc_cfg[MCFG_MBOX_RD_IE]);
   wire host_clr = lb_mbox_rd || lb_mbox_wr;
   wire next_host_irq = host_set || (host_irq_line && !host_clr);

   // Configuration, mask, enable and interrupt outputs.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mask <= MASK_RST;
         global_enable <= ENABLE_RST;
         misc_cfg <= MCFG_RST;
         irq <= 1'b0;
         host_irq_line <= 1'b0;
      end else begin
         mask <= next_mask;
         global_enable <= next_enable;
         misc_cfg <= next_misc;
         irq <= next_irq;
         host_irq_line <= next_host_irq;
      end
   end

   // Mailboxes; the master's write lands after any CPU write of that cycle.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         d2h_mbox <= MBOX_RST;
         h2d_mbox <= MBOX_RST;
         lb_mbox_rdata <= MBOX_RST;
      end else begin
         if (wr_d2h) begin
            d2h_mbox <= reg_wdata[MBOX_W-1:0];
         end
         if (lb_mbox_wr) begin
            h2d_mbox <= lb_mbox_wdata;
         end else if (wr_h2d) begin
            h2d_mbox <= reg_wdata[MBOX_W-1:0];
         end
         // The master's read data at local bus address 8.
         lb_mbox_rdata <= (wr_d2h ? reg_wdata[MBOX_W-1:0] : d2h_mbox);
      end
   end

   // Read data mux; reads have no side effects except the host line.
   // Unmapped offsets and reserved bits read as zero.
   wire [31:0] rd_value =
      reg_hit(reg_addr, OFS_STATUS) ? 32'(status) :
      reg_hit(reg_addr, OFS_MASK) ? 32'(mask) :
      reg_hit(reg_addr, OFS_ENABLE) ? 32'(global_enable) :
      reg_hit(reg_addr, OFS_MISC_CFG) ? misc_cfg :
      reg_hit(reg_addr, OFS_D2H_MBOX) ? 32'(d2h_mbox) :
      reg_hit(reg_addr, OFS_H2D_MBOX) ? 32'(h2d_mbox) :
      32'h00000000;

   // A window access ends on the far side's done or on expiry.
   wire dca_end = (dca_state == LBIM_BUSY) &&
                  (direct_cpu_access_done || tmo_if.expired);

   // Only the low half of the local bus word is carried.
   wire [31:0] dca_rvalue = direct_cpu_access_done ?
      {16'h0000, direct_cpu_access_rdata} : 32'h00000000;

   // Sequencer of single direct accesses; while busy the port waits.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dca_state <= LBIM_IDLE;
         direct_cpu_access_req <= 1'b0;
         direct_cpu_access_write <= 1'b0;
         direct_cpu_access_addr <= '0;
         direct_cpu_access_wdata <= '0;
      end else begin
         case (dca_state)
            LBIM_IDLE: begin
               if (dca_start) begin
                  dca_state <= LBIM_BUSY;
                  direct_cpu_access_req <= 1'b1;
                  direct_cpu_access_write <= reg_write;
                  direct_cpu_access_addr <= reg_addr[16:2];
                  direct_cpu_access_wdata <= reg_wdata[MBOX_W-1:0];
               end
            end
            LBIM_BUSY: begin
               if (dca_end) begin
                  dca_state <= LBIM_IDLE;
                  direct_cpu_access_req <= 1'b0;
               end
            end
            default: begin
               dca_state <= LBIM_IDLE;
               direct_cpu_access_req <= 1'b0;
            end
         endcase
      end
   end

   // Answer path: registers answer next cycle, the window on its end.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_ack <= 1'b0;
         reg_rdata <= 32'h00000000;
      end else begin
         reg_ack <= reg_wr || reg_rd || dca_end;
         if (reg_rd) begin
            reg_rdata <= rd_value;
         end else if (dca_end) begin
            reg_rdata <= dca_rvalue;
         end
      end
   end

   // The timeout watches the window and the slave-side transactions.
   assign tmo_if.pending = lb_txn_pending || (dca_state == LBIM_BUSY);
   assign tmo_if.limit = misc_cfg[MCFG_TMO_MSB:MCFG_TMO_LSB];

   lbim_timeout u_timeout (
      .clk_sys (clk_sys),
      .rst (rst),
      .tmo (tmo_if.tmr)
   );

   // Checks on the block's own registers and outputs.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_dca_taken;
      take && in_window;
   endsequence

   property p_tx_req;
      tx_done && tx_desc_irq_request |=> status[BIT_TX_DESC];
   endproperty
   a_tx_req: assert property (p_tx_req)
      else $error("tx request flag not latched");

   property p_tx_err;
      tx_done && tx_had_error |=> status[BIT_TX_ERR];
   endproperty
   a_tx_err: assert property (p_tx_err)
      else $error("tx error flag not latched");

   property p_rx_eol;
      rx_done && rx_next_desc_link_null |=> status[BIT_RX_EOL];
   endproperty
   a_rx_eol: assert property (p_rx_eol)
      else $error("rx end of list not latched");

   // A register access may be answered in the same cycle as an expiry
   // of a slave-side wait, so only a running window must be aborted.
   property p_tmo;
      tmo_if.expired |=> status[BIT_TIMEOUT] &&
         ($past(dca_state) != LBIM_BUSY ||
          (reg_ack && dca_state == LBIM_IDLE));
   endproperty
   a_tmo: assert property (p_tmo)
      else $error("timeout not flagged");

   property p_proto;
      lb_protocol_err |=> status[BIT_PROTO] &&
         ((status[BIT_TIMEOUT:BIT_TRUNC] & $past(lb_protocol_kind))
          == $past(lb_protocol_kind));
   endproperty
   a_proto: assert property (p_proto)
      else $error("protocol violation not flagged");

   property p_mbox_wr;
      lb_mbox_wr |=> status[BIT_MBOX_WR] &&
         h2d_mbox == $past(lb_mbox_wdata);
   endproperty
   a_mbox_wr: assert property (p_mbox_wr)
      else $error("master mailbox write lost");

   property p_w1c;
      wr_status && reg_wdata[BIT_TX_DESC] && !status_set[BIT_TX_DESC]
         |=> !status[BIT_TX_DESC];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("status bit not cleared by one");

   property p_irq;
      irq == (global_enable && |(status & mask));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt does not follow status");

   property p_host_set;
      wr_d2h && misc_cfg[MCFG_MBOX_WR_IE] |=> host_irq_line;
   endproperty
   a_host_set: assert property (p_host_set)
      else $error("host line not raised");

   property p_host_clr;
      lb_mbox_rd && !host_set |=> !host_irq_line;
   endproperty
   a_host_clr: assert property (p_host_clr)
      else $error("host line not cleared");

   property p_dca_map;
      s_dca_taken |=> direct_cpu_access_req &&
         direct_cpu_access_addr == $past(reg_addr[16:2]);
   endproperty
   a_dca_map: assert property (p_dca_map)
      else $error("window address mapping wrong");

   property p_dca_data;
      dca_end && direct_cpu_access_done |=> reg_ack &&
         reg_rdata[31:16] == 16'h0000;
   endproperty
   a_dca_data: assert property (p_dca_data)
      else $error("window upper data not zero");

endmodule : lbim_top

`default_nettype wire

/* File: bench/lbim_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Far-side slave: answers a direct access after lat cycles.
// A lat of zero never answers, which provokes the timeout abort.
module lbim_far_model
   import lbim_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] lat,
   input wire logic req,
   input wire logic [LB_ADDR_W-1:0] addr,
   output logic done,
   output logic [MBOX_W-1:0] rdata
);
   logic [7:0] cnt; // Cycles spent in the current access.
   logic answered; // Set once this access was answered.

   // Outside the answer cycle and the cycle after it the data lines toggle, so stale data
   // can never pass for a good read.
   always_ff @(posedge clk_sys) begin
      if (rst || !req) begin
         cnt <= 8'h00;
         answered <= 1'b0;
         done <= 1'b0;
         rdata <= rst ? 16'h0000 : ~rdata;
      end else if (!answered && lat != 8'h00 && cnt == lat) begin
         done <= 1'b1;
         answered <= 1'b1;
         rdata <= {1'b1, addr} ^ 16'h5A5A;
      end else begin
         done <= 1'b0;
         cnt <= cnt + 8'h01;
         if (!done) begin
            rdata <= ~rdata;
         end
      end
   end
endmodule : lbim_far_model

`default_nettype wire

/* File: bench/lbim_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module lbim_tb_top;
   import lbim_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic reg_req = 1'b0;
   logic reg_write = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 18'h00000;
   logic [31:0] reg_wdata = 32'h00000000;
   // Event pulses: tx, rx, truncate, starve, protocol, slave
   // timeouts, then master mailbox read and write.
   logic [16:0] evv = 17'h00000;
   logic [2:0] lb_protocol_kind = 3'h5;
   logic lb_txn_pending = 1'b0;
   logic host_mode = 1'b0;
   logic slave_irq = 1'b0;
   logic [MBOX_W-1:0] lb_mbox_wdata = 16'h0000;
   logic [7:0] lat = 8'h03;
   logic [31:0] reg_rdata, q;
   logic reg_ack, host_irq_line, irq, dca_req, dca_wr, dca_done, cap_w;
   logic [LB_ADDR_W-1:0] dca_addr, cap_a;
   logic [MBOX_W-1:0] lb_mbox_rdata, dca_wdata, dca_rdata, cap_d;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;

   lbim_top uut (
      .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
      .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .tx_done(evv[0]), .tx_desc_irq_request(evv[1]),
      .tx_had_error(evv[2]), .tx_next_desc_link_null(evv[3]),
      .rx_done(evv[4]), .rx_desc_irq_request(evv[5]),
      .rx_had_error(evv[6]), .rx_next_desc_link_null(evv[7]),
      .tx_truncated(evv[8]), .tx_starved(evv[9]),
      .lb_protocol_err(evv[10]), .lb_protocol_kind(lb_protocol_kind),
      .lb_txn_pending(lb_txn_pending), .host_mode(host_mode),
      .slave_timeout(evv[14:11]), .slave_irq(slave_irq),
      .lb_mbox_rd(evv[15]), .lb_mbox_wr(evv[16]),
      .lb_mbox_wdata(lb_mbox_wdata), .lb_mbox_rdata(lb_mbox_rdata),
      .host_irq_line(host_irq_line), .irq(irq),
      .direct_cpu_access_req(dca_req),
      .direct_cpu_access_write(dca_wr),
      .direct_cpu_access_addr(dca_addr),
      .direct_cpu_access_wdata(dca_wdata),
      .direct_cpu_access_done(dca_done),
      .direct_cpu_access_rdata(dca_rdata)
   );

   lbim_far_model far (.clk_sys(clk_sys), .rst(rst), .lat(lat),
      .req(dca_req), .addr(dca_addr), .done(dca_done), .rdata(dca_rdata));

   // Free-running 10 MHz clock.
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] b1(input logic x);
      return {31'h0, x};
   endfunction : b1

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   // One register request; the wait is bounded since a window access
   // that nobody answers only ends through the timeout abort.
   task automatic acc(input logic wr, input logic [17:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk_sys) #1;
      reg_req = 1'b1;
      reg_write = wr;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk_sys) #1;
      reg_req = 1'b0;
      n = 0;
      while (reg_ack !== 1'b1 && n < 400) begin
         if (dca_req === 1'b1) begin
            cap_a = dca_addr;
            cap_d = dca_wdata;
            cap_w = dca_wr;
         end
         @(posedge clk_sys) #1;
         n++;
      end
      chk("reg_ack", b1(reg_ack), 32'h1);
      r = reg_rdata;
   endtask : acc

   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      acc(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [17:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0, q);
      chk("reg_rdata", q, e);
   endtask : rd

   task automatic pulse(input logic [16:0] v);
      @(posedge clk_sys) #1;
      evv = v;
      @(posedge clk_sys) #1;
      evv = 17'h00000;
   endtask : pulse

   // Fire events, expect the status, then show write-one-to-clear.
   task automatic ev(input logic [16:0] v, input logic [31:0] e);
      pulse(v);
      rd(OFS_STATUS, e);
      chk("irq", b1(irq), b1(|e));
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, e);
      wr(OFS_STATUS, e);
      rd(OFS_STATUS, 32'h0);
   endtask : ev

   task automatic t_reset;
      rd(OFS_STATUS, 32'h0);
      rd(OFS_MASK, 32'h0);
      rd(OFS_ENABLE, 32'h0);
      rd(OFS_D2H_MBOX, 32'h0);
      rd(OFS_H2D_MBOX, 32'h0);
      rd(18'h00700, 32'h0);
      chk("host_irq_line", b1(host_irq_line), 32'h0);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_events;
      wr(OFS_MASK, 32'h0007FFFF);
      wr(OFS_ENABLE, 32'h1);
      ev(17'h0000F, 32'h0000000D);
      ev(17'h00001, 32'h00000002);
      ev(17'h000F0, 32'h000000D0);
      ev(17'h00010, 32'h00000020);
      ev(17'h00100, 32'h00000100);
      ev(17'h00200, 32'h00000200);
      ev(17'h00400, 32'h00000D00);
      ev(17'h07800, 32'h00000000);
      host_mode = 1'b1;
      ev(17'h07800, 32'h0003C000);
      slave_irq = 1'b1;
      wr(OFS_STATUS, 32'h00040000);
      rd(OFS_STATUS, 32'h00040000);
      slave_irq = 1'b0;
      host_mode = 1'b0;
      wr(OFS_STATUS, 32'h00040000);
      rd(OFS_STATUS, 32'h0);
      $display("t_events done");
   endtask : t_events

   task automatic t_mask;
      wr(OFS_MASK, 32'h0);
      pulse(17'h00001);
      rd(OFS_STATUS, 32'h2);
      chk("irq", b1(irq), 32'h0);
      wr(OFS_MASK, 32'h2);
      chk("irq", b1(irq), 32'h1);
      wr(OFS_ENABLE, 32'h0);
      chk("irq", b1(irq), 32'h0);
      wr(OFS_ENABLE, 32'h1);
      wr(OFS_MASK, 32'h4);
      chk("irq", b1(irq), 32'h0);
      wr(OFS_STATUS, 32'h2);
      wr(OFS_MASK, 32'h0007FFFF);
      $display("t_mask done");
   endtask : t_mask

   task automatic t_mbox;
      wr(OFS_MISC_CFG, 32'h0000000C);
      wr(OFS_D2H_MBOX, 32'hABCD1234);
      chk("lb_mbox_rdata", {16'h0, lb_mbox_rdata}, 32'h1234);
      chk("host_irq_line", b1(host_irq_line), 32'h1);
      rd(OFS_D2H_MBOX, 32'h00001234);
      rd(OFS_STATUS, 32'h0);
      chk("host_irq_line", b1(host_irq_line), 32'h1);
      ev(17'h08000, 32'h00002000);
      chk("host_irq_line", b1(host_irq_line), 32'h0);
      rd(OFS_H2D_MBOX, 32'h0);
      chk("host_irq_line", b1(host_irq_line), 32'h1);
      lb_mbox_wdata = 16'h5A3C;
      ev(17'h10000, 32'h00001000);
      chk("host_irq_line", b1(host_irq_line), 32'h0);
      rd(OFS_H2D_MBOX, 32'h00005A3C);
      wr(OFS_H2D_MBOX, 32'hFFFF9876);
      rd(OFS_H2D_MBOX, 32'h00009876);
      chk("host_irq_line", b1(host_irq_line), 32'h1);
      pulse(17'h08000);
      chk("host_irq_line", b1(host_irq_line), 32'h0);
      wr(OFS_STATUS, 32'h00002000);
      wr(OFS_MISC_CFG, 32'h0);
      wr(OFS_D2H_MBOX, 32'h1);
      chk("host_irq_line", b1(host_irq_line), 32'h0);
      $display("t_mbox done");
   endtask : t_mbox

   task automatic t_window;
      lat = 8'h03;
      wr(OFS_WINDOW | 18'h1234C, 32'hFFFF8765);
      chk("dca_addr", {17'h0, cap_a}, 32'h000048D3);
      chk("dca_wdata", {16'h0, cap_d}, 32'h00008765);
      chk("dca_write", b1(cap_w), 32'h1);
      rd(OFS_WINDOW | 18'h00008, 32'h0000DA58);
      chk("dca_addr", {17'h0, cap_a}, 32'h00000002);
      $display("t_window done");
   endtask : t_window

   // Limit one is 128 cycles; an unanswered window access aborts.
   task automatic t_timeout;
      wr(OFS_MISC_CFG, 32'h00000080);
      lat = 8'h00;
      rd(OFS_WINDOW | 18'h00010, 32'h0);
      rd(OFS_STATUS, 32'h00000400);
      wr(OFS_STATUS, 32'h00000400);
      lat = 8'h03;
      lb_txn_pending = 1'b1;
      repeat (118) @(posedge clk_sys);
      rd(OFS_STATUS, 32'h0);
      repeat (12) @(posedge clk_sys);
      rd(OFS_STATUS, 32'h00000400);
      lb_txn_pending = 1'b0;
      wr(OFS_MISC_CFG, 32'h0);
      wr(OFS_STATUS, 32'h00000400);
      lb_txn_pending = 1'b1;
      repeat (300) @(posedge clk_sys);
      rd(OFS_STATUS, 32'h0);
      lb_txn_pending = 1'b0;
      $display("t_timeout done");
   endtask : t_timeout

   initial begin
      repeat (10) @(posedge clk_sys);
      #1 rst = 1'b0;
      t_reset;
      t_events;
      t_mask;
      t_mbox;
      t_window;
      t_timeout;
      end_sim;
   end

   // The whole run needs about 800 cycles; a hang is cut at 5000.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         $display("[ERR] run_length expected end seen hang");
         end_sim;
      end
   end
endmodule : lbim_tb_top

`default_nettype wire
